// ===== tb/dce_engine_tb.sv
// Self-checking bench of the transfer engine and a memory model.
// Assumes the engine's zero-wait register slave and its register map.
`include "dce_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dce_engine_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic cpu_bus_req = 1'b0;
  logic slow = 1'b0;
  logic [3:0] dreq = 4'h0;
  logic hready, hreadyout, hresp, m_hwrite, m_hready;
  logic [31:0] hrdata, m_haddr, m_hwdata, m_hrdata, q;
  logic [1:0] m_htrans;
  logic [2:0] m_hsize;
  logic [3:0] dack, irq;
  int fails = 0;
  int checks_done = 0;
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  dce_engine u_dce_engine (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .m_haddr(m_haddr),
    .m_htrans(m_htrans), .m_hwrite(m_hwrite), .m_hsize(m_hsize),
    .m_hwdata(m_hwdata), .m_hrdata(m_hrdata), .m_hready(m_hready),
    .cpu_bus_req(cpu_bus_req), .dreq(dreq), .dack(dack), .irq(irq));
  dce_mem_model u_dce_mem_model (.hclk(hclk), .hresetn(hresetn),
    .slow(slow), .m_haddr(m_haddr), .m_htrans(m_htrans),
    .m_hwrite(m_hwrite), .m_hsize(m_hsize), .m_hwdata(m_hwdata),
    .m_hrdata(m_hrdata), .m_hready(m_hready));
  // Peripheral side: request falls once acknowledged
  always @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      if (dack[i] === 1'b1) begin
        dreq[i] <= 1'b0;
      end
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= `DCE_HTRANS_NSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= `DCE_HTRANS_IDLE;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rdchk(input string n, input logic [7:0] a,
      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  task automatic req(input int i);
    int n;
    dreq[i] <= 1'b1;
    n = 0;
    do begin @(negedge hclk); n++; end while (dack[i] !== 1'b1 && n < 99);
    chk("dack_up", 32'h1, {31'h0, dack[i]});
    do begin @(negedge hclk); n++; end while (dack[i] !== 1'b0 && n < 199);
    chk("dreq_low", 32'h0, {31'h0, dreq[i]});
    @(posedge hclk);
  endtask
  task automatic idle_chk(input int i, input string n);
    dreq[i] <= 1'b1;
    repeat (20) @(negedge hclk);
    chk(n, 32'h0, {31'h0, dack[i]});
    @(posedge hclk);
    dreq[i] <= 1'b0;
  endtask
  task automatic t_regs;
    rdchk("cfg_rst", 8'h20, 32'h0);
    bus(1'b1, 8'h28, 32'h88);
    bus(1'b1, 8'h24, 32'h5);
    bus(1'b1, 8'h20, 32'hA01);
    bus(1'b1, 8'h24, 32'h7);
    rdchk("cnt_locked", 8'h24, 32'h5);
    bus(1'b1, 8'h20, 32'hA00);
    rdchk("cfg_kept", 8'h20, 32'hA00);
    rdchk("pbase_kept", 8'h28, 32'h88);
    bus(1'b1, 8'h50, 32'h1);
    rdchk("unmapped", 8'h50, 32'h0);
    idle_chk(2, "dack_disabled");
    $display("t_regs done");
  endtask
  task automatic t_periph;
    logic [31:0] src;
    src = 32'h12345678;
    slow <= 1'b1;
    bus(1'b1, 8'h08, 32'h80);
    bus(1'b1, 8'h0C, 32'h0);
    bus(1'b1, 8'h04, 32'h4);
    bus(1'b1, 8'h00, 32'h867);
    req(0);
    req(0);
    rdchk("half_flag", `DCE_OFS_STAT, 32'h5);
    chk("irq_half", 32'h1, {31'h0, irq[0]});
    req(0);
    req(0);
    rdchk("done_flag", `DCE_OFS_STAT, 32'h7);
    rdchk("cnt_zero", 8'h04, 32'h0);
    rdchk("pbase_held", 8'h08, 32'h80);
    for (int i = 0; i < 4; i++) begin
      chk("item", {24'h0, src[8*i +: 8]}, u_dce_mem_model.mem[i]);
    end
    chk("past_end", 32'hFFFFFFFF, u_dce_mem_model.mem[4]);
    idle_chk(0, "dack_at_zero");
    bus(1'b1, `DCE_OFS_FCLR, 32'h6);
    rdchk("flags_clr", `DCE_OFS_STAT, 32'h0);
    chk("irq_clr", 32'h0, {31'h0, irq[0]});
    slow <= 1'b0;
    $display("t_periph done");
  endtask
  task automatic t_copy;
    int n;
    cpu_bus_req <= 1'b1;
    bus(1'b1, 8'h18, 32'h40);
    bus(1'b1, 8'h1C, 32'h60);
    bus(1'b1, 8'h14, 32'h3);
    bus(1'b1, 8'h10, 32'h4A61);
    n = 0;
    do begin bus(1'b0, 8'h14, 32'h0); n++; end while (q !== 0 && n < 50);
    for (int i = 0; i < 3; i++) begin
      chk("copy", 32'hC0DE0000 + i, u_dce_mem_model.mem[24+i]);
    end
    chk("copy_stop", 32'h0, u_dce_mem_model.mem[27]);
    chk("copy_noack", 32'h0, {31'h0, dack[1]});
    cpu_bus_req <= 1'b0;
    $display("t_copy done");
  endtask
  task automatic both(input logic [31:0] cfg2, input logic [31:0] cfg3);
    int n;
    bus(1'b1, 8'h24, 32'h1);
    bus(1'b1, 8'h34, 32'h1);
    bus(1'b1, 8'h20, cfg2);
    bus(1'b1, 8'h30, cfg3);
    dreq[2] <= 1'b1;
    dreq[3] <= 1'b1;
    n = 0;
    do begin @(negedge hclk); n++; end while ((dreq | dack) !== 0 && n < 99);
    @(posedge hclk);
    bus(1'b1, 8'h20, cfg2 & 32'hFFFE);
    bus(1'b1, 8'h30, cfg3 & 32'hFFFE);
  endtask
  task automatic t_prio;
    bus(1'b1, 8'h28, 32'h90);
    bus(1'b1, 8'h2C, 32'hA0);
    bus(1'b1, 8'h38, 32'h94);
    bus(1'b1, 8'h3C, 32'hA0);
    both(32'h0A01, 32'h3A01);
    chk("prio_order", 32'h22222222, u_dce_mem_model.mem[40]);
    both(32'h1A01, 32'h1A01);
    chk("tie_order", 32'h33333333, u_dce_mem_model.mem[40]);
    $display("t_prio done");
  endtask
  task automatic t_wraparound_mode;
    bus(1'b1, `DCE_OFS_FCLR, 32'hFFFF);
    bus(1'b1, 8'h3C, 32'hB0);
    bus(1'b1, 8'h34, 32'h2);
    bus(1'b1, 8'h30, 32'hA51);
    req(3);
    req(3);
    rdchk("wraparound_mode_cnt", 8'h34, 32'h2);
    rdchk("wraparound_mode_flags", `DCE_OFS_STAT, 32'h7000);
    u_dce_mem_model.mem[44] = 32'h0;
    req(3);
    chk("wraparound_mode_addr", 32'h33333333, u_dce_mem_model.mem[44]);
    chk("wraparound_mode_end", 32'hFFFFFFFF, u_dce_mem_model.mem[46]);
    $display("t_wraparound_mode done");
  endtask
  initial begin
    for (int i = 0; i < 64; i++) begin
      u_dce_mem_model.mem[i] = 32'hFFFFFFFF;
    end
    for (int i = 0; i < 4; i++) begin
      u_dce_mem_model.mem[16+i] = 32'hC0DE0000 + i;
      u_dce_mem_model.mem[24+i] = 32'h0;
    end
    u_dce_mem_model.mem[32] = 32'h12345678;
    u_dce_mem_model.mem[36] = 32'h22222222;
    u_dce_mem_model.mem[37] = 32'h33333333;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_periph;
    t_copy;
    t_prio;
    t_wraparound_mode;
    tally_and_finish;
  end
  initial begin
    #100000;
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ===== tb/dce_mem_model.sv
// Word memory seen by the engine's master port, optional wait states.
// Assumes single transfers; byte lanes follow size and address.
`timescale 1ns/1ps
`default_nettype none
module dce_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic [31:0] m_haddr,
  input wire logic [1:0] m_htrans,
  input wire logic m_hwrite,
  input wire logic [2:0] m_hsize,
  input wire logic [31:0] m_hwdata,
  output logic [31:0] m_hrdata,
  output logic m_hready
);
  logic [31:0] mem [0:63];
  logic [31:0] a_r;
  logic [2:0] s_r;
  logic rd_r;
  logic wr_r;
  logic w_r;
  logic [3:0] be;
  assign m_hready = slow ? w_r : 1'b1;
  assign be = s_r == 3'h0 ? 4'h1 << a_r[1:0] :
    s_r == 3'h1 ? 4'h3 << {a_r[1], 1'b0} : 4'hF;
  // Outside a read data phase the lines show inverted data
  assign m_hrdata = rd_r ? mem[a_r[7:2]] : ~mem[a_r[7:2]];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_r <= 1'b0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      a_r <= 32'h0;
      s_r <= 3'h0;
    end else begin
      w_r <= ~w_r;
      if (wr_r && m_hready) begin
        for (int i = 0; i < 4; i++) begin
          if (be[i]) begin
            mem[a_r[7:2]][8*i +: 8] <= m_hwdata[8*i +: 8];
          end
        end
      end
      if (m_hready) begin
        rd_r <= m_htrans[1] && !m_hwrite;
        wr_r <= m_htrans[1] && m_hwrite;
        if (m_htrans[1]) begin
          a_r <= m_haddr;
          s_r <= m_hsize;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/dce_defines.svh
// Constants of the channel transfer engine: offsets, fields, counts.
// Assumes inclusion by bare name from the bench and the engine.
// Functional notes
// - Engine yields the system bus after each transfer while the processor wants it.
// - Engine raises acknowledge toward the peripheral at its access.
// - Acknowledge holds until request falls, then drops.
// - A transaction reads source, writes destination, then decrements the count.
// - First transaction uses base addresses copied into hidden current addresses.
// - Each channel has a two-bit priority level for arbitration.
// - Equal priority: lower channel number wins.
// - Item count programmable up to 65535, decremented after each transaction.
// - Peripheral and memory item sizes are set independently.
// - With step enabled, address advances by 1, 2 or 4 per item size.
// - Base address registers keep programmed values; only current addresses move.
// - Non-circular channel with zero count serves no requests.
// - Disabling a channel resets none of its registers.
// - Circular mode reloads count and current addresses after last transaction.
// - An enabled channel serves requests from its peripheral.
// - Half of items moved sets half flag; interrupt if enabled.
// - Last item moved sets complete flag; interrupt if enabled.
// - Copy mode runs without requests once enabled, stops at zero count.
// - Channel flags are ORed into one interrupt line per channel.
`ifndef DCE_DEFINES_SVH
`define DCE_DEFINES_SVH
`define DCE_NCH 4
`define DCE_REG_CFG 2'h0
`define DCE_REG_CNT 2'h1
`define DCE_REG_PBASE 2'h2
`define DCE_REG_MBASE 2'h3
`define DCE_OFS_STAT 8'h40
`define DCE_OFS_FCLR 8'h44
`define DCE_FLAG_GIF 0
`define DCE_FLAG_TC 1
`define DCE_FLAG_HT 2
`define DCE_FLAG_W 4
`define DCE_CFG_RST 15'h0000
`define DCE_HTRANS_IDLE 2'h0
`define DCE_HTRANS_NSEQ 2'h2
`endif

// ===== verilog/dce_engine.sv
// Four-channel transfer engine: AHB-Lite register slave, AHB-Lite master.
// Assumes one clock, request pins asynchronous to it, master port alone
// on its bus segment with the fabric arbitration done here.
`include "dce_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dce_engine import dce_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [31:0] m_haddr,
  output logic [1:0] m_htrans,
  output logic m_hwrite,
  output logic [2:0] m_hsize,
  output logic [31:0] m_hwdata,
  input wire logic [31:0] m_hrdata,
  input wire logic m_hready,
  input wire logic cpu_bus_req,
  input wire logic [3:0] dreq,
  output logic [3:0] dack,
  output logic [3:0] irq
);
  localparam int NCH = `DCE_NCH;

  function automatic logic [31:0] step_of(input logic [1:0] sz);
    step_of = 32'h1 << sz;
  endfunction

  // Highest level wins; scanning down lets the lower index win ties
  function automatic logic [2:0] pick(input logic [3:0] elig,
                                     input logic [7:0] pls);
    logic [1:0] best;
    logic found;
    logic [1:0] idx;
    best = 2'h0;
    found = 1'b0;
    idx = 2'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (elig[i] && (!found || pls[2*i +: 2] >= best)) begin
        found = 1'b1;
        best = pls[2*i +: 2];
        idx = 2'(i);
      end
    end
    pick = {found, idx};
  endfunction

  dce_cfg_s cfg_r [NCH];
  logic [15:0] cnt_r [NCH];
  logic [15:0] tot_r [NCH];
  logic [31:0] pbase_r [NCH];
  logic [31:0] mbase_r [NCH];
  logic [31:0] pcur_r [NCH];
  logic [31:0] mcur_r [NCH];
  logic [3:0] tc_r, ht_r, en_d_r, req_m_r, req_s_r, dack_r;
  dce_state_e st_r;
  logic [1:0] cur_r;
  logic [31:0] data_r;
  logic yield_r;
  logic wsel_r;
  logic [7:0] wadr_r;
  logic [31:0] hrdata_r;

  // Register slave, zero wait states
  wire s_acc = hsel & htrans[1] & hready;
  wire [1:0] rch = haddr[5:4];
  wire [1:0] rreg = haddr[3:2];
  wire [31:0] ch_word = (rreg == `DCE_REG_CFG) ? {17'h0, cfg_r[rch]} :
                        (rreg == `DCE_REG_CNT) ? {16'h0, cnt_r[rch]} :
                        (rreg == `DCE_REG_PBASE) ? pbase_r[rch] :
                        mbase_r[rch];
  logic [31:0] stat_w;
  always_comb begin
    stat_w = 32'h0;
    for (int i = 0; i < NCH; i++) begin
      stat_w[`DCE_FLAG_W*i + `DCE_FLAG_GIF] = tc_r[i] | ht_r[i];
      stat_w[`DCE_FLAG_W*i + `DCE_FLAG_TC] = tc_r[i];
      stat_w[`DCE_FLAG_W*i + `DCE_FLAG_HT] = ht_r[i];
    end
  end
  wire [31:0] rd_mux = (haddr[7:6] == 2'h0) ? ch_word :
                       (haddr[7:0] == `DCE_OFS_STAT) ? stat_w : 32'h0;
  wire [1:0] w_ch = wadr_r[5:4];
  wire [1:0] w_reg = wadr_r[3:2];
  wire w_chan = wsel_r && (wadr_r[7:6] == 2'h0);
  wire w_clr = wsel_r && (wadr_r == `DCE_OFS_FCLR);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wsel_r <= 1'b0;
      wadr_r <= 8'h00;
      hrdata_r <= 32'h0;
    end else begin
      wsel_r <= s_acc & hwrite;
      wadr_r <= haddr[7:0];
      if (s_acc && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // Current channel view
  dce_cfg_s cc;
  assign cc = cfg_r[cur_r];
  wire [15:0] cnt_cur = cnt_r[cur_r];
  wire [15:0] tot_cur = tot_r[cur_r];
  wire [31:0] src_a = cc.to_periph ? mcur_r[cur_r] : pcur_r[cur_r];
  wire [31:0] dst_a = cc.to_periph ? pcur_r[cur_r] : mcur_r[cur_r];
  wire [1:0] src_sz = cc.to_periph ? cc.mem_item_size : cc.periph_item_size;
  wire [1:0] dst_sz = cc.to_periph ? cc.periph_item_size : cc.mem_item_size;
  wire wr_done = (st_r == ST_WRD) && m_hready;

  // Eligibility and arbitration
  logic [3:0] elig;
  logic [7:0] pls;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pls[2*i +: 2] = cfg_r[i].prio_level;
      elig[i] = cfg_r[i].enable && en_d_r[i] &&
                (cnt_r[i] != 16'h0) &&
                (cfg_r[i].copy_without_request ||
                 (req_s_r[i] && !dack_r[i]));
    end
  end
  wire [2:0] win = pick(elig, pls);

  // Transfer sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_IDLE;
      cur_r <= 2'h0;
      data_r <= 32'h0;
      yield_r <= 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (yield_r) begin
            yield_r <= 1'b0;
          end else if (win[2]) begin
            cur_r <= win[1:0];
            st_r <= ST_RDA;
          end
        end
        ST_RDA: if (m_hready) st_r <= ST_RDD;
        ST_RDD: begin
          if (m_hready) begin
            data_r <= m_hrdata >> {src_a[1:0], 3'b000};
            st_r <= ST_WRA;
          end
        end
        ST_WRA: if (m_hready) st_r <= ST_WRD;
        ST_WRD: begin
          if (m_hready) begin
            yield_r <= cpu_bus_req;
            st_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Master outputs; narrow writes repeat on every lane
  wire [31:0] item = (src_sz == 2'h0) ? {24'h0, data_r[7:0]} :
                     (src_sz == 2'h1) ? {16'h0, data_r[15:0]} : data_r;
  wire rd_ph = (st_r == ST_RDA) || (st_r == ST_RDD);
  assign m_haddr = rd_ph ? src_a : dst_a;
  assign m_htrans = ((st_r == ST_RDA) || (st_r == ST_WRA)) ?
                    `DCE_HTRANS_NSEQ : `DCE_HTRANS_IDLE;
  assign m_hwrite = (st_r == ST_WRA);
  assign m_hsize = rd_ph ? {1'b0, src_sz} : {1'b0, dst_sz};
  assign m_hwdata = (dst_sz == 2'h0) ? {4{item[7:0]}} :
                    (dst_sz == 2'h1) ? {2{item[15:0]}} : item;

  // Per-channel registers, pointers, flags and handshake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NCH; i++) begin
        cfg_r[i] <= `DCE_CFG_RST;
        cnt_r[i] <= 16'h0;
        tot_r[i] <= 16'h0;
        pbase_r[i] <= 32'h0;
        mbase_r[i] <= 32'h0;
        pcur_r[i] <= 32'h0;
        mcur_r[i] <= 32'h0;
      end
      tc_r <= 4'h0;
      ht_r <= 4'h0;
      en_d_r <= 4'h0;
      req_m_r <= 4'h0;
      req_s_r <= 4'h0;
      dack_r <= 4'h0;
    end else begin
      req_m_r <= dreq;
      req_s_r <= req_m_r;
      for (int i = 0; i < NCH; i++) begin
        en_d_r[i] <= cfg_r[i].enable;
        if (w_chan && w_ch == 2'(i)) begin
          unique case (w_reg)
            `DCE_REG_CFG: cfg_r[i] <= hwdata[14:0];
            `DCE_REG_CNT: begin
              if (!cfg_r[i].enable) begin
                cnt_r[i] <= hwdata[15:0];
                tot_r[i] <= hwdata[15:0];
              end
            end
            `DCE_REG_PBASE: pbase_r[i] <= hwdata;
            `DCE_REG_MBASE: mbase_r[i] <= hwdata;
          endcase
        end
        if (cfg_r[i].enable && !en_d_r[i]) begin
          pcur_r[i] <= pbase_r[i];
          mcur_r[i] <= mbase_r[i];
        end
        if (wr_done && cur_r == 2'(i)) begin
          if (cnt_r[i] == 16'h1 && cfg_r[i].wraparound_mode) begin
            cnt_r[i] <= tot_r[i];
            pcur_r[i] <= pbase_r[i];
            mcur_r[i] <= mbase_r[i];
          end else begin
            cnt_r[i] <= cnt_r[i] - 16'h1;
            if (cfg_r[i].periph_addr_step_on) begin
              pcur_r[i] <= pcur_r[i] +
                           step_of(cfg_r[i].periph_item_size);
            end
            if (cfg_r[i].mem_addr_step_on) begin
              mcur_r[i] <= mcur_r[i] +
                           step_of(cfg_r[i].mem_item_size);
            end
          end
        end
        // Set wins over a same-cycle clear
        tc_r[i] <= (wr_done && cur_r == 2'(i) && cnt_r[i] == 16'h1) ||
                   (tc_r[i] &&
                    !(w_clr && hwdata[`DCE_FLAG_W*i + `DCE_FLAG_TC]));
        ht_r[i] <= (wr_done && cur_r == 2'(i) && tot_r[i] > 16'h1 &&
                    (cnt_r[i] - 16'h1) ==
                    (tot_r[i] - (tot_r[i] >> 1))) ||
                   (ht_r[i] &&
                    !(w_clr && hwdata[`DCE_FLAG_W*i + `DCE_FLAG_HT]));
        if (wr_done && cur_r == 2'(i) &&
            !cfg_r[i].copy_without_request) begin
          dack_r[i] <= 1'b1;
        end else if (dack_r[i] && !req_s_r[i]) begin
          dack_r[i] <= 1'b0;
        end
      end
    end
  end
  assign dack = dack_r;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      irq[i] = (tc_r[i] && cfg_r[i].all_done_irq_on) ||
               (ht_r[i] && cfg_r[i].half_done_irq_on);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_ACK_HOLD: assert property (
    (dack_r & req_s_r) != 4'h0 |=>
      (dack_r & $past(dack_r & req_s_r)) == $past(dack_r & req_s_r))
    else $error("acknowledge dropped while request still high");
  AST_ACK_DROP: assert property (
    (dack_r & ~req_s_r) != 4'h0 |=>
      (dack_r & $past(dack_r & ~req_s_r)) == 4'h0)
    else $error("acknowledge kept after request fell");
  AST_COUNT_DEC: assert property (
    wr_done && cnt_cur != 16'h1 |=> cnt_cur == $past(cnt_cur) - 16'h1)
    else $error("count not decremented after transaction");
  AST_ONLY_ENABLED: assert property (
    $rose(st_r == ST_RDA) |-> cfg_r[cur_r].enable)
    else $error("disabled channel was served");
  AST_ZERO_IDLE: assert property (
    st_r == ST_RDA |-> cnt_cur != 16'h0)
    else $error("channel with zero count was served");
  AST_WRAPAROUND_MODE_RELOAD: assert property (
    wr_done && cnt_cur == 16'h1 && cc.wraparound_mode |=>
      cnt_cur == tot_cur && pcur_r[cur_r] == pbase_r[cur_r])
    else $error("circular reload missing");
  AST_TC_SET: assert property (
    wr_done && cnt_cur == 16'h1 |=> tc_r[cur_r] ##1
      (cfg_r[$past(cur_r, 2)].wraparound_mode ||
       !(st_r == ST_RDA && cur_r == $past(cur_r, 2))))
    else $error("complete flag not set at last item");
  AST_YIELD: assert property (
    wr_done && cpu_bus_req |=> m_htrans == `DCE_HTRANS_IDLE [*2])
    else $error("engine did not yield bus to processor");
  AST_ACK_AFTER: assert property (
    wr_done && !cc.copy_without_request |=> dack_r[$past(cur_r)])
    else $error("no acknowledge after peripheral transaction");

  COV_COPY_DONE: cover property (wr_done && cc.copy_without_request &&
                                 cnt_cur == 16'h1);
  COV_WRAPAROUND_MODE: cover property (wr_done && cc.wraparound_mode &&
                            cnt_cur == 16'h1);
  COV_HALF: cover property ($rose(ht_r[0]));
  COV_HANDSHAKE: cover property ($rose(dack_r[1]) ##[1:20] $fell(dack_r[1]));
endmodule
`default_nettype wire

// ===== verilog/dce_pkg.sv
// Types of the channel transfer engine.
// Assumes nothing beyond the defines header.
package dce_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RDA = 5'h02,
    ST_RDD = 5'h04,
    ST_WRA = 5'h08,
    ST_WRD = 5'h10
  } dce_state_e;
  typedef struct packed {
    logic copy_without_request;
    logic [1:0] prio_level;
    logic [1:0] mem_item_size;
    logic [1:0] periph_item_size;
    logic rsv;
    logic mem_addr_step_on;
    logic periph_addr_step_on;
    logic wraparound_mode;
    logic to_periph;
    logic half_done_irq_on;
    logic all_done_irq_on;
    logic enable;
  } dce_cfg_s;
endpackage
